// *** core/llp_defines.vh ***
`ifndef LLP_DEFINES_VH
`define LLP_DEFINES_VH

// Bus widths of the pin interface
`define LLP_DQ_W 36
`define LLP_ADDR_W 20
`define LLP_BA_W 4
`define LLP_MODE_W 24
`define LLP_NGRP 2
`define LLP_GRP_W 18
`define LLP_NQK 4

// Command/address bundle layout after synchronising
`define LLP_CA_W 28
`define LLP_CA_CS 27
`define LLP_CA_SPARE 26
`define LLP_CA_WE 25
`define LLP_CA_REF 24
`define LLP_CA_BA_HI 23
`define LLP_CA_BA_LO 20
`define LLP_CA_A_HI 19

// Storage: bank plus low column bits
`define LLP_IDX_W 6
`define LLP_COL_W 2
`define LLP_DEPTH 64
`define LLP_IDX_ODD 6'h01

// Commands as {write_enable_n, refresh_n}
`define LLP_CMD_MRS 2'h0
`define LLP_CMD_WR 2'h1
`define LLP_CMD_REF 2'h2
`define LLP_CMD_RD 2'h3

// Read sequencing
`define LLP_CNT_W 4
`define LLP_RD_LAT 4'h4
`define LLP_BEAT0 2'h0
`define LLP_BEAT1 2'h1
`define LLP_BEAT_END 2'h2

// Lanes in use per configuration
`define LLP_X18_LANES 36'h0_0003_FFFF
`define LLP_X36_LANES 36'hF_FFFF_FFFF
`define LLP_X18_QK 4'h3
`define LLP_X36_QK 4'hF

`endif

// *** core/llp_pin_iface.v ***
`timescale 1ns/1ps
`include "llp_defines.vh"

module llp_pin_iface (
	// System
	input wire mclk,
	input wire reset_n,
	// Static straps
	input wire mirror_strap,
	input wire cfg_x36,
	// Command and address pins
	input wire ck,
	input wire cs_n,
	input wire spare_cs,
	input wire we_n,
	input wire ref_n,
	input wire [`LLP_BA_W-1:0] ba,
	input wire [`LLP_ADDR_W-1:0] addr,
	// Write data pins
	input wire [`LLP_NGRP-1:0] write_data_clock,
	input wire [`LLP_NGRP-1:0] write_byte_mask,
	input wire [`LLP_DQ_W-1:0] dq_i,
	// Read data pins
	output reg [`LLP_DQ_W-1:0] dq_o,
	output reg [`LLP_DQ_W-1:0] dq_oe,
	output reg [`LLP_NQK-1:0] read_data_clock,
	output reg [`LLP_NQK-1:0] read_data_clock_n,
	output reg [`LLP_NGRP-1:0] read_valid_flag,
	// Mode register contents
	output reg [`LLP_MODE_W-1:0] mode_settings
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_WAIT = 3'b010;
	localparam [2:0] ST_BURST = 3'b100;

	// Clamshell mounting swaps mirror-image balls pairwise
	function [`LLP_CA_W-1:0] llp_mirror;
		input [`LLP_CA_W-1:0] b;
		reg [`LLP_CA_W-1:0] m;
		begin
			m = b;
			m[`LLP_CA_CS] = b[0];
			m[0] = b[`LLP_CA_CS];
			m[5] = b[`LLP_CA_SPARE];
			m[`LLP_CA_SPARE] = b[5];
			m[`LLP_CA_WE] = b[`LLP_CA_REF];
			m[`LLP_CA_REF] = b[`LLP_CA_WE];
			m[`LLP_CA_BA_LO] = b[`LLP_CA_BA_LO+1];
			m[`LLP_CA_BA_LO+1] = b[`LLP_CA_BA_LO];
			m[`LLP_CA_BA_HI] = b[`LLP_CA_BA_HI-1];
			m[`LLP_CA_BA_HI-1] = b[`LLP_CA_BA_HI];
			m[7] = b[9];
			m[9] = b[7];
			m[2] = b[4];
			m[4] = b[2];
			m[1] = b[3];
			m[3] = b[1];
			m[15] = b[18];
			m[18] = b[15];
			m[6] = b[8];
			m[8] = b[6];
			m[19] = b[10];
			m[10] = b[19];
			m[14] = b[12];
			m[12] = b[14];
			m[16] = b[17];
			m[17] = b[16];
			m[11] = b[13];
			m[13] = b[11];
			llp_mirror = m;
		end
	endfunction

	// Slice of the data word owned by one write data clock
	function [`LLP_GRP_W-1:0] llp_slice;
		input sel;
		input [`LLP_DQ_W-1:0] w;
		begin
			if (sel)
				llp_slice = {w[35:27], w[17:9]};
			else
				llp_slice = {w[26:18], w[8:0]};
		end
	endfunction

	// Every pin passes two flops before use
	reg ck_s1_q, ck_s2_q, ck_s3_q;
	reg [`LLP_NGRP-1:0] dk_s1_q, dk_s2_q, dk_s3_q;
	reg [`LLP_NGRP-1:0] dm_s1_q, dm_s2_q;
	reg [`LLP_DQ_W-1:0] dq_s1_q, dq_s2_q;
	reg [`LLP_CA_W-1:0] ca_s1_q, ca_s2_q;
	reg strap_s1_q, strap_q, x36_s1_q, x36_q;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ck_s1_q <= 1'b0;
			ck_s2_q <= 1'b0;
			ck_s3_q <= 1'b0;
			dk_s1_q <= {`LLP_NGRP{1'b0}};
			dk_s2_q <= {`LLP_NGRP{1'b0}};
			dk_s3_q <= {`LLP_NGRP{1'b0}};
			dm_s1_q <= {`LLP_NGRP{1'b0}};
			dm_s2_q <= {`LLP_NGRP{1'b0}};
			dq_s1_q <= {`LLP_DQ_W{1'b0}};
			dq_s2_q <= {`LLP_DQ_W{1'b0}};
			ca_s1_q <= {`LLP_CA_W{1'b1}};
			ca_s2_q <= {`LLP_CA_W{1'b1}};
			strap_s1_q <= 1'b0;
			strap_q <= 1'b0;
			x36_s1_q <= 1'b0;
			x36_q <= 1'b0;
		end else begin
			ck_s1_q <= ck;
			ck_s2_q <= ck_s1_q;
			ck_s3_q <= ck_s2_q;
			dk_s1_q <= write_data_clock;
			dk_s2_q <= dk_s1_q;
			dk_s3_q <= dk_s2_q;
			dm_s1_q <= write_byte_mask;
			dm_s2_q <= dm_s1_q;
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
			ca_s1_q <= {cs_n, spare_cs, we_n, ref_n, ba, addr};
			ca_s2_q <= ca_s1_q;
			strap_s1_q <= mirror_strap;
			strap_q <= strap_s1_q;
			x36_s1_q <= cfg_x36;
			x36_q <= x36_s1_q;
		end
	end

	// Command decode
	wire [`LLP_CA_W-1:0] ca_l;
	wire ck_rise;
	wire cmd_go;
	wire [1:0] cmd;
	wire [`LLP_IDX_W-1:0] cmd_idx;
	wire wr_busy;
	wire [`LLP_NGRP-1:0] pend_all;
	wire wr_go;
	wire rd_go;

	assign ca_l = strap_q ? llp_mirror(ca_s2_q) : ca_s2_q;
	assign ck_rise = ck_s2_q & ~ck_s3_q;
	// Deselected cycles only stop decode; bursts in flight run on
	assign cmd_go = ck_rise & ~ca_l[`LLP_CA_CS];
	assign cmd = {ca_l[`LLP_CA_WE], ca_l[`LLP_CA_REF]};
	assign cmd_idx = {ca_l[`LLP_CA_BA_HI:`LLP_CA_BA_LO],
		ca_l[`LLP_COL_W-1:0]};
	assign wr_busy = |pend_all;
	assign wr_go = cmd_go & (cmd == `LLP_CMD_WR) & ~wr_busy;

	// Read burst state
	reg [2:0] st_q;
	reg [`LLP_CNT_W-1:0] cnt_q;
	reg [1:0] rbeat_q;
	reg [`LLP_IDX_W-1:0] ridx_q;
	wire [`LLP_IDX_W-1:0] rd_adr;
	wire [`LLP_DQ_W-1:0] rd_word;
	wire [`LLP_NGRP*`LLP_GRP_W-1:0] rdat_all;
	wire [`LLP_DQ_W-1:0] lanes;
	wire [`LLP_NQK-1:0] qk_used;

	assign rd_go = cmd_go & (cmd == `LLP_CMD_RD) & st_q[0];
	assign rd_adr = (rbeat_q == `LLP_BEAT0) ? ridx_q : ridx_q ^ `LLP_IDX_ODD;
	assign rd_word = {rdat_all[35:27], rdat_all[17:9],
		rdat_all[26:18], rdat_all[8:0]};
	assign lanes = x36_q ? `LLP_X36_LANES : `LLP_X18_LANES;
	assign qk_used = x36_q ? `LLP_X36_QK : `LLP_X18_QK;

	// Per write data clock: own edges, own mask, own slice of storage
	genvar g;
	generate
		for (g = 0; g < `LLP_NGRP; g = g + 1) begin : grp
			reg [`LLP_GRP_W-1:0] mem [0:`LLP_DEPTH-1];
			reg pend_q;
			reg beat_q;
			reg [`LLP_IDX_W-1:0] idx_q;
			wire dk_rise;
			wire dk_fall;
			wire take;
			wire [`LLP_IDX_W-1:0] wadr;
			wire [`LLP_GRP_W-1:0] rdat;

			assign dk_rise = dk_s2_q[g] & ~dk_s3_q[g];
			assign dk_fall = ~dk_s2_q[g] & dk_s3_q[g];
			// Beat 0 on the rising edge, beat 1 on the falling edge
			assign take = pend_q & ((~beat_q & dk_rise) |
				(beat_q & dk_fall));
			assign wadr = beat_q ? idx_q ^ `LLP_IDX_ODD : idx_q;
			assign rdat = mem[rd_adr];
			assign rdat_all[g*`LLP_GRP_W +: `LLP_GRP_W] = rdat;
			assign pend_all[g] = pend_q;

			always @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					pend_q <= 1'b0;
					beat_q <= 1'b0;
					idx_q <= {`LLP_IDX_W{1'b0}};
				end else if (wr_go) begin
					pend_q <= 1'b1;
					beat_q <= 1'b0;
					idx_q <= cmd_idx;
				end else if (take) begin
					beat_q <= ~beat_q;
					pend_q <= ~beat_q;
				end
			end

			// A masked beat still advances, it only skips the store
			always @(posedge mclk) begin
				if (take & ~dm_s2_q[g]) begin
					mem[wadr] <= llp_slice(g == 1, dq_s2_q);
				end
			end
		end
	endgenerate

	// Mode register set
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mode_settings <= {`LLP_MODE_W{1'b0}};
		end else if (cmd_go & (cmd == `LLP_CMD_MRS)) begin
			mode_settings <= ca_l[`LLP_CA_BA_HI:0];
		end
	end

	// Read clocks in use toggle every cycle so each cycle is one data beat
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			read_data_clock <= {`LLP_NQK{1'b0}};
			read_data_clock_n <= {`LLP_NQK{1'b0}};
		end else begin
			read_data_clock <= {`LLP_NQK{~read_data_clock[0]}} &
				qk_used;
			read_data_clock_n <= {`LLP_NQK{read_data_clock[0]}} &
				qk_used;
		end
	end

	// Read sequencing
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= ST_IDLE;
			cnt_q <= {`LLP_CNT_W{1'b0}};
			rbeat_q <= `LLP_BEAT0;
			ridx_q <= {`LLP_IDX_W{1'b0}};
			read_valid_flag <= {`LLP_NGRP{1'b0}};
			dq_o <= {`LLP_DQ_W{1'b0}};
			dq_oe <= {`LLP_DQ_W{1'b0}};
		end else begin
			case (st_q)
			ST_IDLE: begin
				if (rd_go) begin
					ridx_q <= cmd_idx;
					cnt_q <= `LLP_RD_LAT;
					st_q <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (cnt_q != {`LLP_CNT_W{1'b0}}) begin
					cnt_q <= cnt_q - 1'b1;
				end else if (read_data_clock[0]) begin
					// Clock falls now and rises with the first beat
					read_valid_flag <= {x36_q, 1'b1};
					rbeat_q <= `LLP_BEAT0;
					st_q <= ST_BURST;
				end
			end
			ST_BURST: begin
				case (rbeat_q)
				`LLP_BEAT0: begin
					dq_o <= rd_word & lanes;
					dq_oe <= lanes;
					rbeat_q <= `LLP_BEAT1;
				end
				`LLP_BEAT1: begin
					dq_o <= rd_word & lanes;
					read_valid_flag <= {`LLP_NGRP{1'b0}};
					rbeat_q <= `LLP_BEAT_END;
				end
				default: begin
					dq_oe <= {`LLP_DQ_W{1'b0}};
					rbeat_q <= `LLP_BEAT0;
					st_q <= ST_IDLE;
				end
				endcase
			end
			default: begin
				st_q <= ST_IDLE;
			end
			endcase
		end
	end

endmodule // llp_pin_iface

// *** sim/llp_checker.sv ***
`timescale 1ns/1ps
`include "llp_defines.vh"
module llp_checker (
	// Clock, reset and straps
	input wire mclk,
	input wire reset_n,
	input wire mirror_strap,
	input wire cfg_x36,
	// Command pins
	input wire cs_n,
	input wire we_n,
	input wire ref_n,
	input wire [3:0] ba,
	input wire [19:0] addr,
	// Read side
	input wire [35:0] dq_oe,
	input wire [3:0] read_data_clock,
	input wire [3:0] read_data_clock_n,
	input wire [1:0] read_valid_flag,
	input wire [23:0] mode_settings
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Straps need two edges to settle, so clock checks wait a few cycles
	reg [2:0] up_q;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			up_q <= 3'h0;
		else if (up_q != 3'h7)
			up_q <= up_q + 3'h1;
	end
	wire run = up_q == 3'h7;
	qk_compl_a: assert property (
		run |-> read_data_clock[1:0] == ~read_data_clock_n[1:0])
		else $error("read clock legs not complementary");
	qk_free_a: assert property (
		run |=> $changed(read_data_clock[0]))
		else $error("read clock not toggling");
	qk_park_a: assert property (
		run && !cfg_x36 |-> {read_data_clock[3:2], read_data_clock_n[3:2]} == 4'h0)
		else $error("unused read clocks not parked");
	qk_x36_a: assert property (
		run && cfg_x36 |-> read_data_clock == {4{read_data_clock[0]}})
		else $error("read clocks out of step");
	vld_lead_a: assert property (
		$rose(read_valid_flag[0]) |=> dq_oe[0] && $rose(read_data_clock[0]))
		else $error("valid not one edge ahead of data");
	vld_len_a: assert property (
		$rose(read_valid_flag[0]) |-> read_valid_flag[0] [*2]
		##1 (!read_valid_flag[0] && dq_oe[0]) ##1 !dq_oe[0])
		else $error("read burst window wrong");
	vld_pair_a: assert property (
		read_valid_flag[1] |-> cfg_x36 && read_valid_flag[0])
		else $error("second valid flag out of place");
	oe_lanes_a: assert property (
		dq_oe[0] |-> dq_oe == (cfg_x36 ? `LLP_X36_LANES : `LLP_X18_LANES))
		else $error("driven lanes wrong");
	mrs_load_a: assert property (
		$changed(mode_settings) && !mirror_strap |->
		$past({cs_n, we_n, ref_n}, 3) == 3'h0 && mode_settings == $past({ba, addr}, 3))
		else $error("mode settings changed without mode command");
endmodule // llp_checker

bind llp_pin_iface llp_checker llp_checker_i (.mclk(mclk), .reset_n(reset_n),
	.mirror_strap(mirror_strap), .cfg_x36(cfg_x36), .cs_n(cs_n), .we_n(we_n),
	.ref_n(ref_n), .ba(ba), .addr(addr), .dq_oe(dq_oe),
	.read_data_clock(read_data_clock), .read_data_clock_n(read_data_clock_n),
	.read_valid_flag(read_valid_flag), .mode_settings(mode_settings));

// *** sim/llp_ctrl_model.sv ***
`timescale 1ns/1ps
module llp_ctrl_model (
	// Command and address pins
	output reg ck,
	output reg cs_n,
	output reg spare_cs,
	output reg we_n,
	output reg ref_n,
	output reg [3:0] ba,
	output reg [19:0] addr,
	// Write data pins
	output wire [1:0] write_data_clock,
	output reg [1:0] write_byte_mask,
	output reg [35:0] dq_i
);
	// Data clocks lag half a period so a write is armed before its data
	assign write_data_clock = {2{~ck}};
	initial begin
		{cs_n, spare_cs, we_n, ref_n, ba, addr, write_byte_mask, dq_i} = ~66'h0;
		ck = 1'b0;
		#3;
		forever #100 ck = ~ck;
	end
	// c is {cs_n, spare_cs, we_n, ref_n}; m is {beat1 mask, beat0 mask}
	task xfer(input [3:0] c, input [3:0] b, input [19:0] a,
		input [35:0] d0, input [35:0] d1, input [3:0] m);
		begin
			@(negedge ck);
			{cs_n, spare_cs, we_n, ref_n} = c;
			ba = b;
			addr = a;
			@(posedge ck);
			#50;
			dq_i = d0;
			write_byte_mask = m[1:0];
			@(negedge ck);
			cs_n = 1'b1;
			{spare_cs, we_n, ref_n} = ~c[2:0];
			ba = ~b;
			addr = {~a[19:1], 1'b1};
			#50;
			dq_i = d1;
			write_byte_mask = m[3:2];
			@(posedge ck);
			#50;
			dq_i = ~d1;
			write_byte_mask = ~m[3:2];
		end
	endtask
endmodule // llp_ctrl_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`include "llp_defines.vh"
module testbench;
	localparam [35:0] S0 = 36'h0_07FC_01FF;
	localparam [35:0] S1 = 36'hF_F803_FE00;
	reg mclk, reset_n, mirror_strap, cfg_x36;
	wire ck, cs_n, spare_cs, we_n, ref_n;
	wire [3:0] ba, read_data_clock, read_data_clock_n;
	wire [19:0] addr;
	wire [1:0] write_data_clock, write_byte_mask, read_valid_flag;
	wire [35:0] dq_i, dq_o, dq_oe;
	wire [23:0] mode_settings;
	integer err_count, compares;
	reg [35:0] mem [0:63];
	llp_pin_iface llp_pin_iface_i (.mclk(mclk), .reset_n(reset_n),
		.mirror_strap(mirror_strap), .cfg_x36(cfg_x36), .ck(ck),
		.cs_n(cs_n), .spare_cs(spare_cs), .we_n(we_n), .ref_n(ref_n),
		.ba(ba), .addr(addr), .write_data_clock(write_data_clock),
		.write_byte_mask(write_byte_mask), .dq_i(dq_i), .dq_o(dq_o),
		.dq_oe(dq_oe), .read_data_clock(read_data_clock),
		.read_data_clock_n(read_data_clock_n),
		.read_valid_flag(read_valid_flag), .mode_settings(mode_settings));
	llp_ctrl_model llp_ctrl_model_i (.ck(ck), .cs_n(cs_n),
		.spare_cs(spare_cs), .we_n(we_n), .ref_n(ref_n), .ba(ba),
		.addr(addr), .write_data_clock(write_data_clock),
		.write_byte_mask(write_byte_mask), .dq_i(dq_i));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task tick;
		begin
			@(posedge mclk);
			#2;
		end
	endtask
	task test_done;
		begin
			$display("compares %0d err_count %0d", compares, err_count);
			if (err_count == 0 && compares > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input [35:0] exp, input [35:0] got, input [47:0] nm);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("unexpected %0s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	task do_reset(input x36, input mir);
		begin
			tick;
			reset_n = 1'b0;
			cfg_x36 = x36;
			mirror_strap = mir;
			#3;
			chk(36'h0, {6'h0, read_valid_flag, read_data_clock,
				mode_settings}, "reset");
			repeat (16) tick;
			reset_n = 1'b1;
			repeat (8) tick;
		end
	endtask
	task put(input [5:0] i, input [35:0] d, input [1:0] m);
		begin
			if (!m[0])
				mem[i] = (mem[i] & ~S0) | (d & S0);
			if (!m[1])
				mem[i] = (mem[i] & ~S1) | (d & S1);
		end
	endtask
	task wr(input [5:0] i, input [35:0] d0, input [35:0] d1, input [3:0] m);
		begin
			llp_ctrl_model_i.xfer(4'h5, i[5:2], {18'h15A5A, i[1:0]}, d0, d1, m);
			put(i, d0, m[1:0]);
			put(i ^ 6'h01, d1, m[3:2]);
		end
	endtask
	task rd(input [5:0] i);
		integer n;
		reg [35:0] ln;
		begin
			ln = cfg_x36 ? `LLP_X36_LANES : `LLP_X18_LANES;
			n = 0;
			// The burst is still running when the command call returns
			fork
				llp_ctrl_model_i.xfer(4'h7, i[5:2], {18'h15A5A, i[1:0]},
					36'h0, 36'h0, 4'hF);
				begin
					while (read_valid_flag[0] !== 1'b1 && n < 40) begin
						tick;
						n = n + 1;
					end
					if (read_valid_flag[0] !== 1'b1) begin
						chk(36'h1, 36'h0, "tmo");
					end else begin
						chk({34'h0, cfg_x36, 1'b1}, {34'h0, read_valid_flag},
							"valid");
						tick;
						chk(mem[i] & ln, dq_o & ln, "beat0");
						chk(ln, dq_oe, "lanes");
						tick;
						chk(mem[i ^ 6'h01] & ln, dq_o & ln, "beat1");
					end
				end
			join
		end
	endtask
	task t_mode;
		begin
			llp_ctrl_model_i.xfer(4'h0, 4'hA, 20'h5A3C9, 36'h0, 36'h0, 4'hF);
			repeat (8) tick;
			chk(36'hA5A3C9, {12'h0, mode_settings}, "mode");
			llp_ctrl_model_i.xfer(4'h2, 4'h1, 20'h0F0F0, 36'h0, 36'h0, 4'hF);
			llp_ctrl_model_i.xfer(4'h8, 4'h3, 20'h12345, 36'h0, 36'h0, 4'hF);
			repeat (8) tick;
			chk(36'hA5A3C9, {12'h0, mode_settings}, "mode");
		end
	endtask
	task t_data;
		begin
			wr(6'h05, 36'h1_2345_6789, 36'hA_BCDE_F012, 4'h0);
			wr(6'h39, 36'h5_5AA5_3CC3, 36'h9_8765_4321, 4'h0);
			wr(6'h05, 36'hF_0F0F_0F0F, 36'h0_F0F0_F0F0, 4'h9);
			rd(6'h05);
			rd(6'h39);
		end
	endtask
	task t_mirror;
		begin
			llp_ctrl_model_i.xfer(4'hC, 4'hF, 20'hFFFFE, 36'h0, 36'h0, 4'hF);
			repeat (8) tick;
			chk(36'hFFFFFF, {12'h0, mode_settings}, "mirror");
			llp_ctrl_model_i.xfer(4'h8, 4'hF, 20'hFFFFE, 36'h0, 36'h0, 4'hF);
			repeat (8) tick;
			chk(36'hFFFFDF, {12'h0, mode_settings}, "spare");
		end
	endtask
	initial begin
		err_count = 0;
		compares = 0;
		reset_n = 1'b0;
		cfg_x36 = 1'b1;
		mirror_strap = 1'b0;
		do_reset(1'b1, 1'b0);
		t_mode;
		t_data;
		do_reset(1'b0, 1'b0);
		wr(6'h22, 36'h3_C3C3_C3C3, 36'hC_3C3C_3C3C, 4'h0);
		rd(6'h22);
		do_reset(1'b1, 1'b1);
		t_mirror;
		test_done;
	end
endmodule // testbench
